// File: gced_pkg.sv
// Shared constants and types for the remote command and error decoder
package gced_pkg;

  // Error codes, two hex characters each
  localparam logic [7:0] ERR_RAM      = 8'h01;
  localparam logic [7:0] ERR_ROM      = 8'h02;
  localparam logic [7:0] ERR_INSTPORT = 8'h03;
  localparam logic [7:0] ERR_BCDPORT  = 8'h04;
  localparam logic [7:0] ERR_SWEEP    = 8'h05;
  localparam logic [7:0] ERR_ADDR     = 8'h06;
  localparam logic [7:0] ERR_LEGACY   = 8'h07;
  localparam logic [7:0] ERR_EXT      = 8'h08;
  localparam logic [7:0] ERR_LEVEL    = 8'h09;
  localparam logic [7:0] ERR_MOD      = 8'h0a;
  localparam logic [7:0] ERR_NONE     = 8'h00;

  // Highest bus address accepted from the keyboard
  localparam logic [4:0] MAX_BUS_ADDR = 5'h1e;

  // Modulation limits, in units of the argument (three digits)
  localparam logic [9:0] AM_MAX_PCT  = 10'h063;
  localparam logic [9:0] PM_MAX_DEG  = 10'h063;
  localparam logic [9:0] FM_MAX_KHZ  = 10'h3de;
  localparam logic [9:0] FM_MIN_KHZ  = 10'h001;
  localparam logic [1:0] MAX_DIGITS  = 2'h3;

  // Dispatched function codes
  typedef enum logic [4:0] {
    FN_NONE, FN_CENTER, FN_UP, FN_DOWN, FN_INCR, FN_LEVEL, FN_FMDEV, FN_AMDEPTH,
    FN_PMDEV, FN_MODOFF, FN_FMCAL, FN_HALF, FN_SRC, FN_WIDTH, FN_SWMODE,
    FN_SWRATE, FN_BLANK, FN_SHOW, FN_CLEAR
  } gced_fn_t;

  // Parser states
  typedef enum logic [2:0] {
    PS_FIRST, PS_SECOND, PS_ARG, PS_UNIT2, PS_WORD2, PS_WORD3
  } gced_ps_t;

endpackage

// File: gced_decoder.sv
// Remote command parser, limit checker and error code reporter
// Summary of operation
// - Report 01 on power-up RAM failure
// - Report 02 on ROM checksum mismatch
// - Report 03 on instrument port read-back error
// - Report 04 on BCD port read-back error
// - Keep latest error 01-05 for redisplay
// - Report 05 when sweep leaves carrier range
// - Reject keyboard bus address above 30, 06
// - Legacy set: unknown character gives 07
// - Extended set: unknown character gives 08
// - Level out of range: 09, command dropped
// - Output level takes three significant digits
// - Modulation level out of range gives 0A
// - Modulation argument takes three significant digits
// - Deviation: up to three digits, then units
// - Envelope depth is read as percent
// - Phase depth is read in degrees
// - Reset or legacy select: legacy set only
// - Extended select: extended set until legacy
`timescale 1ns/1ps

module gced_decoder (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Received bus characters
  input  wire logic                 rxValid,
  input  wire logic [7:0]           rxChar,
  input  wire logic                 legacyValid,
  // Self test results, one-cycle pulses
  input  wire logic                 ramFail,
  input  wire logic                 romFail,
  input  wire logic                 instPortFail,
  input  wire logic                 bcdPortFail,
  // Sweep check
  input  wire logic                 sweepOn,
  input  wire logic                 sweepLowUnder,
  input  wire logic                 sweepHighOver,
  input  wire logic                 sweepCheck,
  // Keyboard address entry
  input  wire logic                 kbAddrValid,
  input  wire logic [7:0]           kbAddr,
  // Level check from the RF section
  input  wire logic                 levelOutOfRange,
  // Operator redisplay request
  input  wire logic                 shiftError,
  // Mode and dispatch
  output logic                      extendedSet,
  output logic                      cmdValid,
  output gced_pkg::gced_fn_t        cmdFn,
  output logic [9:0]                cmdArg,
  output logic [7:0]                cmdUnit,
  output logic                      cmdLevelNeg,
  // Error display and accepted bus address
  output logic                      errValid,
  output logic [7:0]                errCode,
  output logic [15:0]               errText,
  output logic [7:0]                savedErr,
  output logic                      bindAddrValid,
  output logic [4:0]                busAddr
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rstMeta_r;                       // First stage
  logic rstSync_r;                       // Released reset, active low

  // Two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Character is a decimal digit
  function automatic logic isDigit(input logic [7:0] c);
    isDigit = (c >= 8'h30) && (c <= 8'h39);
  endfunction

  // Hex nibble to ASCII character
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Upper-case letter and letter or digit to function code
  function automatic gced_pkg::gced_fn_t pairFn(input logic [7:0] a, input logic [7:0] b);
    pairFn = gced_pkg::FN_NONE;
    unique case ({a, b})
      16'h4652: pairFn = gced_pkg::FN_CENTER;   // Center tune
      16'h5550: pairFn = gced_pkg::FN_UP;
      16'h444e: pairFn = gced_pkg::FN_DOWN;     // Step decrease
      16'h4953: pairFn = gced_pkg::FN_INCR;     // Increment set
      16'h4150: pairFn = gced_pkg::FN_LEVEL;    // Output level
      16'h464d: pairFn = gced_pkg::FN_FMDEV;    // Frequency deviation
      16'h414d: pairFn = gced_pkg::FN_AMDEPTH;  // Envelope depth
      16'h504d: pairFn = gced_pkg::FN_PMDEV;    // Phase deviation
      16'h4d4f: pairFn = gced_pkg::FN_MODOFF;
      16'h4643: pairFn = gced_pkg::FN_FMCAL;
      16'h434e: pairFn = gced_pkg::FN_HALF;     // Half deviation
      16'h4d31, 16'h4d32, 16'h4d34, 16'h4d38, 16'h4d39: pairFn = gced_pkg::FN_SRC;
      16'h4653: pairFn = gced_pkg::FN_WIDTH;
      16'h5730, 16'h5731, 16'h5732, 16'h5733: pairFn = gced_pkg::FN_SWMODE;
      16'h5431, 16'h5432, 16'h5433: pairFn = gced_pkg::FN_SWRATE;
      16'h4442: pairFn = gced_pkg::FN_BLANK;
      16'h444f: pairFn = gced_pkg::FN_SHOW;
      default: pairFn = gced_pkg::FN_NONE;
    endcase
  endfunction

  // Code that takes a numeric argument and a unit
  function automatic logic takesArg(input gced_pkg::gced_fn_t f);
    takesArg = (f == gced_pkg::FN_CENTER) || (f == gced_pkg::FN_INCR) ||
               (f == gced_pkg::FN_LEVEL) || (f == gced_pkg::FN_FMDEV) ||
               (f == gced_pkg::FN_AMDEPTH) || (f == gced_pkg::FN_PMDEV) ||
               (f == gced_pkg::FN_WIDTH);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Parser state
  gced_pkg::gced_ps_t ps_r;              // Parser state
  logic [7:0]         first_r;           // First letter of the pair
  logic [7:0]         unit1_r;           // First character of the unit
  gced_pkg::gced_fn_t fn_r;              // Code awaiting its argument
  logic [9:0]         arg_r;             // Accumulated argument
  logic [1:0]         digits_r;          // Significant digits seen
  logic               neg_r;             // Minus sign seen in the argument
  logic [1:0]         wordSel_r;         // Mode word being matched: 1 legacy, 2 ext
  logic               badChar;           // Unrecognised character this cycle
  logic               modeLegacy;        // Legacy select completed
  logic               modeExt;           // Extended select completed
  logic               argDone;           // Argument with unit completed
  logic               simpleDone;        // Code without argument completed

  // Classify the received character against the parser state
  always_comb begin
    badChar    = 1'b0;
    modeLegacy = 1'b0;
    modeExt    = 1'b0;
    argDone    = 1'b0;
    simpleDone = 1'b0;
    if (rxValid) begin
      unique case (ps_r)
        gced_pkg::PS_FIRST: begin
          // Letters only; separators are ignored
          badChar = !((rxChar >= 8'h41 && rxChar <= 8'h5a) || rxChar == 8'h20 ||
                      rxChar == 8'h0d || rxChar == 8'h0a || rxChar == 8'h2c);
        end
        gced_pkg::PS_SECOND: begin
          if ({first_r, rxChar} == 16'h4f4c || {first_r, rxChar} == 16'h4e45) begin
            badChar = 1'b0;
          end else if (pairFn(first_r, rxChar) == gced_pkg::FN_NONE) begin
            badChar = 1'b1;
          end else begin
            simpleDone = !takesArg(pairFn(first_r, rxChar));
          end
        end
        gced_pkg::PS_ARG: begin
          // Sign, digits, point, then unit letters
          if (isDigit(rxChar)) begin
            badChar = (digits_r == gced_pkg::MAX_DIGITS);
          end else begin
            badChar = !(rxChar == 8'h2b || rxChar == 8'h2d || rxChar == 8'h2e ||
                        (rxChar >= 8'h41 && rxChar <= 8'h5a));
          end
        end
        gced_pkg::PS_UNIT2: begin
          argDone = 1'b1;
        end
        gced_pkg::PS_WORD2: begin
          badChar = !((wordSel_r == 2'h1 && rxChar == 8'h44) ||
                      (wordSel_r == 2'h2 && rxChar == 8'h57));
        end
        default: badChar = 1'b1;
      endcase
    end
    // Completion of a mode word
    if (rxValid && ps_r == gced_pkg::PS_WORD2 && !badChar) begin
      modeLegacy = (wordSel_r == 2'h1);
      modeExt    = (wordSel_r == 2'h2);
    end
  end

  // Parser sequencing, extended set only
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      ps_r      <= gced_pkg::PS_FIRST;
      first_r   <= 8'h00;
      unit1_r   <= 8'h00;
      fn_r      <= gced_pkg::FN_NONE;
      arg_r     <= 10'h000;
      digits_r  <= 2'h0;
      neg_r     <= 1'b0;
      wordSel_r <= 2'h0;
    end else if (rxValid && extendedSet) begin
      if (badChar) begin
        ps_r <= gced_pkg::PS_FIRST;
      end else begin
        unique case (ps_r)
          gced_pkg::PS_FIRST: begin
            if (rxChar >= 8'h41 && rxChar <= 8'h5a) begin
              first_r <= rxChar;
              ps_r    <= gced_pkg::PS_SECOND;
            end
          end
          gced_pkg::PS_SECOND: begin
            if ({first_r, rxChar} == 16'h4f4c) begin
              wordSel_r <= 2'h1;
              ps_r      <= gced_pkg::PS_WORD2;
            end else if ({first_r, rxChar} == 16'h4e45) begin
              wordSel_r <= 2'h2;
              ps_r      <= gced_pkg::PS_WORD2;
            end else if (takesArg(pairFn(first_r, rxChar))) begin
              fn_r     <= pairFn(first_r, rxChar);
              arg_r    <= 10'h000;
              digits_r <= 2'h0;
              neg_r    <= 1'b0;
              ps_r     <= gced_pkg::PS_ARG;
            end else begin
              ps_r <= gced_pkg::PS_FIRST;
            end
          end
          gced_pkg::PS_ARG: begin
            if (isDigit(rxChar)) begin
              // Decimal accumulate of up to three digits
              arg_r <= 10'((arg_r * 10'h00a) + {6'h00, rxChar[3:0]});
              if (digits_r != 2'h0 || rxChar != 8'h30) begin
                digits_r <= 2'(digits_r + 2'h1);
              end
            end else if (rxChar == 8'h2d) begin
              neg_r <= 1'b1;
            end else if (rxChar >= 8'h41 && rxChar <= 8'h5a) begin
              unit1_r <= rxChar;
              ps_r    <= gced_pkg::PS_UNIT2;
            end
          end
          gced_pkg::PS_UNIT2: ps_r <= gced_pkg::PS_FIRST;
          // Mode word ends on its last letter; the next letter starts a code
          gced_pkg::PS_WORD2: ps_r <= gced_pkg::PS_FIRST;
          gced_pkg::PS_WORD3: ps_r <= gced_pkg::PS_FIRST;
        endcase
      end
    end else if (!extendedSet) begin
      ps_r <= gced_pkg::PS_FIRST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code set selection

  // Legacy after reset; extended select arrives pre-decoded by the legacy path
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      extendedSet <= 1'b0;
    end else if (extendedSet && modeLegacy) begin
      extendedSet <= 1'b0;
    end else if (!extendedSet && legacyValid && rxValid && rxChar == 8'hff) begin
      extendedSet <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dispatch and limit checks
  logic unitOk;                          // Unit pair fits the code
  logic modBad;                          // Modulation argument out of limits

  // Units and limits of the completed argument
  always_comb begin
    unitOk = 1'b1;
    modBad = 1'b0;
    unique case (fn_r)
      gced_pkg::FN_AMDEPTH: begin
        unitOk = ({unit1_r, rxChar} == 16'h5043);
        modBad = (arg_r > gced_pkg::AM_MAX_PCT);
      end
      gced_pkg::FN_PMDEV: begin
        unitOk = ({unit1_r, rxChar} == 16'h4447);
        modBad = (arg_r > gced_pkg::PM_MAX_DEG);
      end
      gced_pkg::FN_FMDEV: begin
        unitOk = ({unit1_r, rxChar} == 16'h4b5a);
        modBad = (arg_r > gced_pkg::FM_MAX_KHZ) || (arg_r < gced_pkg::FM_MIN_KHZ);
      end
      default: ;
    endcase
  end

  // Output one dispatched command per completed code that passes its unit and limit checks
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      cmdValid    <= 1'b0;
      cmdFn       <= gced_pkg::FN_NONE;
      cmdArg      <= 10'h000;
      cmdUnit     <= 8'h00;
      cmdLevelNeg <= 1'b0;
    end else begin
      cmdValid <= 1'b0;
      if (extendedSet && simpleDone) begin
        cmdValid <= 1'b1;
        cmdFn    <= pairFn(first_r, rxChar);
        cmdArg   <= 10'h000;
        cmdUnit  <= 8'h00;
      end else if (extendedSet && argDone && unitOk && !modBad &&
                   !(fn_r == gced_pkg::FN_LEVEL && levelOutOfRange)) begin
        cmdValid    <= 1'b1;
        cmdFn       <= fn_r;
        cmdArg      <= arg_r;
        cmdUnit     <= rxChar;
        cmdLevelNeg <= neg_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error reporting
  logic [7:0] errNow;                    // Error raised this cycle

  // Priority of simultaneous error sources, self test first
  always_comb begin
    errNow = gced_pkg::ERR_NONE;
    if (ramFail) begin
      errNow = gced_pkg::ERR_RAM;
    end else if (romFail) begin
      errNow = gced_pkg::ERR_ROM;
    end else if (instPortFail) begin
      errNow = gced_pkg::ERR_INSTPORT;
    end else if (bcdPortFail) begin
      errNow = gced_pkg::ERR_BCDPORT;
    end else if (sweepCheck && sweepOn && (sweepLowUnder || sweepHighOver)) begin
      errNow = gced_pkg::ERR_SWEEP;
    end else if (kbAddrValid && kbAddr > {3'h0, gced_pkg::MAX_BUS_ADDR}) begin
      errNow = gced_pkg::ERR_ADDR;
    end else if (!extendedSet && legacyValid && rxValid && rxChar == 8'h00) begin
      errNow = gced_pkg::ERR_LEGACY;
    end else if (extendedSet && (badChar || (argDone && !unitOk))) begin
      errNow = gced_pkg::ERR_EXT;
    end else if (extendedSet && argDone && fn_r == gced_pkg::FN_LEVEL && levelOutOfRange) begin
      errNow = gced_pkg::ERR_LEVEL;
    end else if (extendedSet && argDone && modBad) begin
      errNow = gced_pkg::ERR_MOD;
    end
  end

  // Display the code, keep self-test and sweep errors for redisplay
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      errValid <= 1'b0;
      errCode  <= gced_pkg::ERR_NONE;
      errText  <= 16'h3030;
      savedErr <= gced_pkg::ERR_NONE;
    end else begin
      errValid <= 1'b0;
      if (errNow != gced_pkg::ERR_NONE) begin
        errValid <= 1'b1;
        errCode  <= errNow;
        errText  <= {hexChar(errNow[7:4]), hexChar(errNow[3:0])};
        if (errNow <= gced_pkg::ERR_SWEEP) begin
          savedErr <= errNow;
        end
      end else if (shiftError && savedErr != gced_pkg::ERR_NONE) begin
        errValid <= 1'b1;
        errCode  <= savedErr;
        errText  <= {hexChar(savedErr[7:4]), hexChar(savedErr[3:0])};
      end
    end
  end

  // Keyboard address accepted only up to the limit
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      bindAddrValid <= 1'b0;
      busAddr       <= 5'h00;
    end else begin
      bindAddrValid <= 1'b0;
      if (kbAddrValid && kbAddr <= {3'h0, gced_pkg::MAX_BUS_ADDR}) begin
        bindAddrValid <= 1'b1;
        busAddr       <= kbAddr[4:0];
      end
    end
  end

endmodule

// File: gced_decoder_asserts.sv
// Concurrent checks on the ports of the command and error decoder
`timescale 1ns/1ps

module gced_decoder_chk (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // Inputs of the decoder
  input wire logic                 rxValid,
  input wire logic [7:0]           rxChar,
  input wire logic                 legacyValid,
  input wire logic                 ramFail, romFail, instPortFail, bcdPortFail,
  input wire logic                 sweepOn, sweepLowUnder, sweepHighOver, sweepCheck,
  input wire logic                 kbAddrValid,
  input wire logic [7:0]           kbAddr,
  input wire logic                 levelOutOfRange, shiftError,
  // Outputs of the decoder
  input wire logic                 extendedSet, cmdValid,
  input wire gced_pkg::gced_fn_t   cmdFn,
  input wire logic [9:0]           cmdArg,
  input wire logic [7:0]           cmdUnit,
  input wire logic                 cmdLevelNeg, errValid,
  input wire logic [7:0]           errCode,
  input wire logic [15:0]          errText,
  input wire logic [7:0]          savedErr,
  input wire logic                 bindAddrValid,
  input wire logic [4:0]           busAddr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Sweep range fault and bad keyboard address this cycle
  wire logic swBad = sweepCheck && sweepOn && (sweepLowUnder || sweepHighOver);
  wire logic adBad = kbAddrValid && (kbAddr > 8'h1e);
  // Any self test, sweep or address fault outranks a bus character fault
  wire logic hiErr = ramFail || romFail || instPortFail || bcdPortFail || swBad || adBad;

  // ASCII digit for one nibble of an error code
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  a_ram_err: assert property (ramFail |=> errValid && errCode == 8'h01)
    else $error("ram fault not reported");
  a_rom_err: assert property (romFail && !ramFail |=> errValid && errCode == 8'h02)
    else $error("rom fault not reported");
  a_inst_err: assert property (instPortFail && !ramFail && !romFail |=>
    errValid && errCode == 8'h03) else $error("instrument port fault not reported");
  a_bcd_err: assert property (bcdPortFail && !(ramFail || romFail || instPortFail) |=>
    errValid && errCode == 8'h04) else $error("bcd port fault not reported");
  a_sweep_err: assert property (swBad && !(ramFail || romFail || instPortFail ||
    bcdPortFail) |=> errValid && errCode == 8'h05) else $error("sweep fault not reported");
  a_addr_bad: assert property (adBad && !(ramFail || romFail ||
    instPortFail || bcdPortFail || swBad) |=> errValid && errCode == 8'h06)
    else $error("bad address not reported");
  a_addr_take: assert property (kbAddrValid && kbAddr <= 8'h1e |=>
    bindAddrValid && busAddr == $past(kbAddr[4:0])) else $error("address not accepted");
  a_saved_keep: assert property (errValid && errCode != 8'h00 && errCode <= 8'h05 |=>
    savedErr == $past(errCode) || (errValid && errCode <= 8'h05))
    else $error("saved error lost");
  a_err_text: assert property (errValid |->
    errText == {hexc(errCode[7:4]), hexc(errCode[3:0])}) else $error("error text wrong");
  a_ext_sel: assert property (rxValid && legacyValid && rxChar == 8'hff |=> extendedSet)
    else $error("extended set not selected");
  a_legacy_err: assert property (rxValid && legacyValid && rxChar == 8'h00 &&
    !extendedSet && !hiErr |=> errValid && errCode == 8'h07)
    else $error("legacy fault not reported");

  // Main scenarios reached
  c_ext: cover property ($rose(extendedSet));
  c_cmd: cover property (cmdValid && cmdFn == gced_pkg::FN_FMDEV);
  c_mod: cover property (errValid && errCode == 8'h0a);
endmodule

bind gced_decoder gced_decoder_chk chk_u (.*);

// File: gced_bus_ctrl.sv
// Behavioural bus controller that sends ASCII command characters
`timescale 1ns/1ps

module gced_bus_ctrl #(
  parameter bit HALF_NEEDED = 1'b1  // Modulation sections that need halving fitted
) (
  // Clock
  input  wire logic       ref_clk,
  // Character stream
  output logic            rxValid,
  output logic [7:0]      rxChar,
  output logic            legacyValid
);
  initial begin
    rxValid     = 1'b0;
    rxChar      = 8'h00;
    legacyValid = 1'b0;
  end

  // One character per clock, then idle with a scrambled character line
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge ref_clk);
      rxValid     <= 1'b1;
      rxChar      <= s[i];
      legacyValid <= 1'b0;
    end
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxChar  <= ~rxChar;
  endtask

  // Result of the outside legacy parser for one character
  task automatic legacy(input logic [7:0] c);
    @(posedge ref_clk);
    rxValid     <= 1'b1;
    rxChar      <= c;
    legacyValid <= 1'b1;
    @(posedge ref_clk);
    rxValid     <= 1'b0;
    legacyValid <= 1'b0;
    rxChar      <= ~c;
  endtask

  // Modulation value: never more than three digits, halving sent first where needed
  task automatic send_mod(input string code, input int v, input string unit);
    if (HALF_NEEDED)
      send("CN");
    send({code, $sformatf("%03d", v % 1000), unit});
  endtask
endmodule

// File: gced_decoder_tb_top.sv
// Self-checking testbench of the command and error decoder
`timescale 1ns/1ps

module gced_decoder_tb_top;
  logic                ref_clk, rst_n;
  logic [6:0]          ev;          // Pulses: ram rom inst bcd sweep addr shift
  logic                sweepOn, sweepLowUnder, sweepHighOver, levelOutOfRange;
  logic [7:0]          kbAddr;
  logic                rxValid, legacyValid, extendedSet, cmdValid, cmdLevelNeg;
  logic                errValid, bindAddrValid;
  logic [7:0]          rxChar, cmdUnit, errCode, savedErr;
  logic [9:0]          cmdArg;
  logic [15:0]         errText;
  logic [4:0]          busAddr;
  gced_pkg::gced_fn_t  cmdFn;
  int                  error_cnt, checks_done, cyc, seed;

  gced_bus_ctrl ctl_u (.ref_clk(ref_clk), .rxValid(rxValid), .rxChar(rxChar),
    .legacyValid(legacyValid));

  gced_decoder dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .rxValid(rxValid), .rxChar(rxChar),
    .legacyValid(legacyValid), .ramFail(ev[0]), .romFail(ev[1]), .instPortFail(ev[2]),
    .bcdPortFail(ev[3]), .sweepOn(sweepOn), .sweepLowUnder(sweepLowUnder),
    .sweepHighOver(sweepHighOver), .sweepCheck(ev[4]), .kbAddrValid(ev[5]), .kbAddr(kbAddr),
    .levelOutOfRange(levelOutOfRange), .shiftError(ev[6]), .extendedSet(extendedSet),
    .cmdValid(cmdValid), .cmdFn(cmdFn), .cmdArg(cmdArg), .cmdUnit(cmdUnit),
    .cmdLevelNeg(cmdLevelNeg), .errValid(errValid), .errCode(errCode), .errText(errText),
    .savedErr(savedErr), .bindAddrValid(bindAddrValid), .busAddr(busAddr));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling on the run length
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  // Compare one value
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One pulse on the event inputs
  task automatic pulse(input logic [6:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 7'h00;
  endtask

  // Optional characters, then watch four cycles; k: 0 none, 1 command, 2 error, 3 address
  task automatic run(input string s, input int k, input logic [9:0] v,
                     input gced_pkg::gced_fn_t fn, input logic [7:0] u);
    logic sc, se, sb;
    logic [15:0] f, a, un, c, b;
    sc = 0; se = 0; sb = 0;
    if (s.len() > 0)
      ctl_u.send(s);
    repeat (4) begin
      #1;
      if (cmdValid === 1'b1) begin
        sc = 1; f = 16'(cmdFn); a = 16'(cmdArg); un = 16'(cmdUnit);
      end
      if (errValid === 1'b1) begin
        se = 1; c = 16'(errCode);
      end
      if (bindAddrValid === 1'b1) begin
        sb = 1; b = 16'(busAddr);
      end
      @(posedge ref_clk);
    end
    chk(16'({sc, se, sb}), (k == 0) ? 16'h0000 : 16'(8 >> k));
    if (k == 1) begin
      chk(f, 16'(fn)); chk(a, 16'(v)); chk(un, 16'(u));
    end
    if (k == 2)
      chk(c, 16'(v));
    if (k == 3)
      chk(b, 16'(v[4:0]));
    $display("test %s done", (s.len() > 0) ? s : "event");
  endtask

  // Single place where the run ends
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    string cd[3], un[3], tb[6];
    gced_pkg::gced_fn_t fns[3], tf[6];
    int v, kk, lim[3];
    cd = '{"FM", "AM", "PM"}; un = '{"KZ", "PC", "DG"}; lim = '{990, 99, 99};
    fns = '{gced_pkg::FN_FMDEV, gced_pkg::FN_AMDEPTH, gced_pkg::FN_PMDEV};
    tb = '{"UP", "DN", "MO", "CN", "DB", "DO"};
    tf = '{gced_pkg::FN_UP, gced_pkg::FN_DOWN, gced_pkg::FN_MODOFF, gced_pkg::FN_HALF,
           gced_pkg::FN_BLANK, gced_pkg::FN_SHOW};
    seed = 32'h5c17dcec; error_cnt = 0; checks_done = 0; cyc = 0; rst_n = 1'b0;
    ev = 7'h00; sweepOn = 0; sweepLowUnder = 0; sweepHighOver = 0; levelOutOfRange = 0;
    kbAddr = 8'h00;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(16'({extendedSet, savedErr}), 16'h0000);
    chk(errText, 16'h3030);
    for (int i = 0; i < 4; i++) begin
      pulse(7'(1 << i));
      run("", 2, 10'(i + 1), gced_pkg::FN_NONE, 8'h00);
      chk(16'(savedErr), 16'(i + 1));
    end
    pulse(7'h03);
    run("", 2, 10'h001, gced_pkg::FN_NONE, 8'h00);
    sweepLowUnder <= 1'b1;
    pulse(7'h10);
    run("", 0, 10'h000, gced_pkg::FN_NONE, 8'h00);
    sweepOn <= 1'b1;
    pulse(7'h10);
    run("", 2, 10'h005, gced_pkg::FN_NONE, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 30 : (i == 1) ? 31 : ($random(seed) & 8'hff);
      kbAddr <= 8'(v);
      pulse(7'h20);
      run("", (v > 30) ? 2 : 3, (v > 30) ? 10'h006 : 10'(v), gced_pkg::FN_NONE, 8'h00);
    end
    pulse(7'h40);
    run("", 2, 10'h005, gced_pkg::FN_NONE, 8'h00);
    ctl_u.legacy(8'h00);
    run("", 2, 10'h007, gced_pkg::FN_NONE, 8'h00);
    run("FM150KZ", 0, 10'h000, gced_pkg::FN_NONE, 8'h00);
    ctl_u.legacy(8'hff);
    run("", 0, 10'h000, gced_pkg::FN_NONE, 8'h00);
    chk(16'(extendedSet), 16'h0001);
    run("FM150KZ", 1, 10'd150, gced_pkg::FN_FMDEV, "Z");
    run("AM050PC", 1, 10'd50, gced_pkg::FN_AMDEPTH, "C");
    run("PM099DG", 1, 10'd99, gced_pkg::FN_PMDEV, "G");
    run("AM100PC", 2, 10'h00a, gced_pkg::FN_NONE, 8'h00);
    run("PM100DG", 2, 10'h00a, gced_pkg::FN_NONE, 8'h00);
    run("FM991KZ", 2, 10'h00a, gced_pkg::FN_NONE, 8'h00);
    run("FM000KZ", 2, 10'h00a, gced_pkg::FN_NONE, 8'h00);
    run("AM050DG", 2, 10'h008, gced_pkg::FN_NONE, 8'h00);
    run("QQ", 2, 10'h008, gced_pkg::FN_NONE, 8'h00);
    run("AP-12DM", 1, 10'd12, gced_pkg::FN_LEVEL, "M");
    chk(16'(cmdLevelNeg), 16'h0001);
    levelOutOfRange <= 1'b1;
    run("AP123DM", 2, 10'h009, gced_pkg::FN_NONE, 8'h00);
    levelOutOfRange <= 1'b0;
    for (int i = 0; i < 6; i++)
      run(tb[i], 1, 10'h000, tf[i], 8'h00);
    for (int i = 0; i < 12; i++) begin
      kk = $unsigned($random(seed)) % 3;
      v = $unsigned($random(seed)) % ((kk == 0) ? 1000 : 200);
      ctl_u.send_mod(cd[kk], v, un[kk]);
      if (v > lim[kk] || v < ((kk == 0) ? 1 : 0))
        run("", 2, 10'h00a, gced_pkg::FN_NONE, 8'h00);
      else
        run("", 1, 10'(v), fns[kk], un[kk][1]);
    end
    run("OLD", 0, 10'h000, gced_pkg::FN_NONE, 8'h00);
    chk(16'(extendedSet), 16'h0000);
    run("FM150KZ", 0, 10'h000, gced_pkg::FN_NONE, 8'h00);
    finish_test();
  end
endmodule
